// ---- hw/stcr_ctrl.v ----
// Serial transceiver control/status bank with FIFOs, vectoring and masking
`timescale 1ns/100ps
`include "stcr_regs.vh"
module stcr_ctrl #(
   parameter DEPTH = `STCR_FIFO_DEPTH
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Transceiver clock enable, one pulse per transceiver clock period
   input wire i_xclk_en,
   // Transceiver datapath side
   input wire i_rx_serial,
   input wire i_tx_serial_raw,
   input wire i_tx_active_raw,
   input wire i_tx_active_early,
   input wire i_rx_push,
   input wire [10:0] i_rx_word,
   input wire i_rx_msg_end,
   input wire i_rx_active,
   input wire i_rx_error,
   input wire i_rx_parity_err,
   input wire i_rx_addr7,
   input wire i_rx_autoresp,
   input wire i_rx_pollack,
   input wire i_rx_poll,
   input wire [4:0] i_err_codes,
   input wire i_tx_pop,
   output reg [11:0] o_tx_word,
   output reg o_tx_word_valid,
   output reg o_tx_serial,
   output reg o_tx_active_out,
   output reg o_rx_serial,
   output reg o_rx_enable,
   output reg o_xcvr_reset,
   output reg [2:0] o_protocol_sel,
   output reg o_quiesce_3,
   output reg o_rx_input_sel,
   output reg [2:0] o_rx_upper_bits,
   output reg o_err_read,
   // Interrupt side
   input wire i_bidir_is_output,
   input wire i_tx_irq_cause,
   input wire i_bidir_irq_in,
   input wire i_timer_irq_cause,
   input wire i_nmi,
   output reg o_irq,
   output reg [15:0] o_vector,
   output reg o_bidir_irq_pin_o,
   output reg o_bidir_irq_pin_oe
);

   // Software visible registers
   reg [7:0] vector_base_high_reg;
   reg [7:0] irq_ctl_reg;
   reg [7:0] cmd_reg;
   reg [7:0] mode_reg;
   reg lta_reg;
   reg data_err_msg_end_reg;
   reg rar_reg;
   reg ack_reg;
   reg poll_reg;
   reg la_reg;
   reg [4:0] idle_cnt_reg;
   reg rx_last_reg;
   // FIFO storage; depth stays small, so two-bit pointers suffice
   reg [11:0] tx_mem [0:DEPTH-1];
   reg [10:0] rx_mem [0:DEPTH-1];
   reg [1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   reg [2:0] tx_cnt_reg, rx_cnt_reg;
   reg ovf_reg;

   // Access decode; error select steals the data port location
   wire xres = mode_reg[`STCR_M_XCVR_RESET_BIT];
   wire sec = cmd_reg[`STCR_C_SEC];
   wire fifo_wr = i_wr && (i_addr == `STCR_OFS_FIFO) && !sec;
   wire fifo_rd = i_rd && (i_addr == `STCR_OFS_FIFO) && !sec;
   wire err_rd = i_rd && (i_addr == `STCR_OFS_FIFO) && sec;
   wire [2:0] proto = mode_reg[2:0];
   wire coax = (proto == `STCR_PS_COAX);
   wire twinax = (proto == `STCR_PS_TWINAX) || (proto == `STCR_PS_TWINAXP);
   // Occupancy flags straight from the counts
   wire tx_empty = (tx_cnt_reg == 3'h0);
   wire rx_empty = (rx_cnt_reg == 3'h0);
   wire rx_full = (rx_cnt_reg == `STCR_RX_FULL_WORDS);
   wire tx_full = (tx_cnt_reg == DEPTH[2:0]);
   wire tx_push = fifo_wr && !tx_full;
   wire rx_pop = fifo_rd && !rx_empty;
   wire rx_push_ok = i_rx_push && !rx_full;
   wire tx_pop_ok = i_tx_pop && !tx_empty;
   wire lta_wr1 = i_wr && (i_addr == `STCR_OFS_FLAGS) && i_wdata[`STCR_F_LTA];
   // Loopback routes transmit data internally
   wire line_in = mode_reg[`STCR_M_LOOP] ? o_tx_serial : i_rx_serial;
   wire rx_data = line_in ^ mode_reg[`STCR_M_RIN];
   // Flag byte in the order software reads it
   wire [7:0] flags = {tx_empty, rx_full, la_reg, lta_reg, data_err_msg_end_reg, rar_reg, ack_reg, poll_reg};

   // Pointer advance with wrap at depth
   function [1:0] stcr_inc;
      input [1:0] p;
      begin
         stcr_inc = (p == DEPTH[1:0] - 2'h1) ? 2'h0 : p + 2'h1;
      end
   endfunction

   // Software registers; reset bit survives transceiver reset by design
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         vector_base_high_reg <= `STCR_RST_VBASE;
         irq_ctl_reg <= `STCR_RST_IRQCTL;
         cmd_reg <= `STCR_RST_CMD;
         mode_reg <= `STCR_RST_MODE;
      end else if (i_wr) begin
         case (i_addr)
            `STCR_OFS_VBASE: vector_base_high_reg <= i_wdata;
            `STCR_OFS_IRQCTL: irq_ctl_reg <= i_wdata;
            `STCR_OFS_CMD: cmd_reg <= i_wdata;
            `STCR_OFS_MODE: mode_reg <= i_wdata;
            default: ;
         endcase
      end
   end

   // Transmit FIFO: parity select, upper bits, written byte
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_wp_reg <= 2'h0;
         tx_rp_reg <= 2'h0;
         tx_cnt_reg <= 3'h0;
      end else if (xres) begin
         tx_wp_reg <= 2'h0;
         tx_rp_reg <= 2'h0;
         tx_cnt_reg <= 3'h0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp_reg] <= {cmd_reg[`STCR_C_OWP], cmd_reg[2:0], i_wdata};
            tx_wp_reg <= stcr_inc(tx_wp_reg);
         end
         if (tx_pop_ok)
            tx_rp_reg <= stcr_inc(tx_rp_reg);
         if (tx_push && !tx_pop_ok)
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
         else if (!tx_push && tx_pop_ok)
            tx_cnt_reg <= tx_cnt_reg - 3'h1;
      end
   end

   // Receive FIFO; overflow noted when a word arrives with three held
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_wp_reg <= 2'h0;
         rx_rp_reg <= 2'h0;
         rx_cnt_reg <= 3'h0;
         ovf_reg <= 1'b0;
      end else if (xres) begin
         rx_wp_reg <= 2'h0;
         rx_rp_reg <= 2'h0;
         rx_cnt_reg <= 3'h0;
         ovf_reg <= 1'b0;
      end else begin
         if (rx_push_ok) begin
            rx_mem[rx_wp_reg] <= i_rx_word;
            rx_wp_reg <= stcr_inc(rx_wp_reg);
         end
         if (rx_pop)
            rx_rp_reg <= stcr_inc(rx_rp_reg);
         if (rx_push_ok && !rx_pop)
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
         else if (!rx_push_ok && rx_pop)
            rx_cnt_reg <= rx_cnt_reg - 3'h1;
         if (i_rx_push && rx_full)
            ovf_reg <= 1'b1;
         else if (err_rd)
            ovf_reg <= 1'b0;
      end
   end

   // Line-turnaround and data-read-cleared flags; set wins over clear
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lta_reg <= 1'b0;
         data_err_msg_end_reg <= 1'b0;
         rar_reg <= 1'b0;
         ack_reg <= 1'b0;
         poll_reg <= 1'b0;
      end else if (xres) begin
         lta_reg <= 1'b0;
         data_err_msg_end_reg <= 1'b0;
         rar_reg <= 1'b0;
         ack_reg <= 1'b0;
         poll_reg <= 1'b0;
      end else begin
         // A one written to the flag bit, or any FIFO data write, clears turnaround; zero flag writes are ignored
         if (i_rx_msg_end)
            lta_reg <= 1'b1;
         else if (fifo_wr || lta_wr1)
            lta_reg <= 1'b0;
         if (i_rx_push && (coax ? i_rx_parity_err : (twinax && i_rx_addr7)))
            data_err_msg_end_reg <= 1'b1;
         else if (fifo_rd)
            data_err_msg_end_reg <= 1'b0;
         if (i_rx_push && coax && i_rx_autoresp)
            rar_reg <= 1'b1;
         else if (fifo_rd)
            rar_reg <= 1'b0;
         if (i_rx_push && coax && i_rx_pollack)
            ack_reg <= 1'b1;
         else if (fifo_rd)
            ack_reg <= 1'b0;
         if (i_rx_push && coax && i_rx_poll)
            poll_reg <= 1'b1;
         else if (fifo_rd)
            poll_reg <= 1'b0;
      end
   end

   // Line activity: counts transceiver clocks since the last edge
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         la_reg <= 1'b0;
         idle_cnt_reg <= 5'h00;
         rx_last_reg <= 1'b0;
      end else if (xres) begin
         la_reg <= 1'b0;
         idle_cnt_reg <= 5'h00;
         rx_last_reg <= rx_data;
      end else begin
         rx_last_reg <= rx_data;
         if (rx_data != rx_last_reg) begin
            la_reg <= 1'b1;
            idle_cnt_reg <= 5'h00;
         end else if (i_xclk_en && la_reg) begin
            if (idle_cnt_reg == `STCR_IDLE_XCLKS - 1) begin
               la_reg <= 1'b0;
               idle_cnt_reg <= 5'h00;
            end else begin
               idle_cnt_reg <= idle_cnt_reg + 5'h01;
            end
         end
      end
   end

   // Interrupt causes after masking; bidir bit is forced low when pin drives
   reg rx_cause;
   reg [4:0] pend;
   always @* begin
      case (irq_ctl_reg[7:6])
         `STCR_RIS_FULL: rx_cause = rx_full | i_rx_error;
         `STCR_RIS_DAV: rx_cause = !rx_empty | i_rx_error;
         `STCR_RIS_ACTIVE: rx_cause = i_rx_active;
         default: rx_cause = 1'b0;
      endcase
      pend = {i_timer_irq_cause, i_bidir_irq_in & !i_bidir_is_output, lta_reg,
              i_tx_irq_cause, rx_cause} & ~irq_ctl_reg[4:0];
   end

   // Vector and request output, NMI highest priority, then receiver
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq <= 1'b0;
         o_vector <= 16'h0000;
      end else begin
         o_irq <= i_nmi | (|pend);
         if (i_nmi)
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_NMI};
         else if (pend[0])
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_RX};
         else if (pend[1])
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_TX};
         else if (pend[2])
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_LTA};
         else if (pend[3])
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_BIDIR};
         else
            o_vector <= {vector_base_high_reg, 2'h0, `STCR_VEC_TIMER};
      end
   end

   // Register read port; data one cycle after the strobe
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
         o_rx_upper_bits <= 3'h0;
         o_err_read <= 1'b0;
      end else begin
         o_err_read <= err_rd;
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `STCR_OFS_VBASE: o_rdata <= vector_base_high_reg;
               // Reserved bit reads zero; software must not rely on it
               `STCR_OFS_IRQCTL: o_rdata <= {irq_ctl_reg[7:6], 1'b0, irq_ctl_reg[4:0]};
               `STCR_OFS_FLAGS: o_rdata <= flags;
               `STCR_OFS_FIFO: begin
                  if (sec)
                     o_rdata <= {3'h0, ovf_reg | i_err_codes[4], i_err_codes[3:0]};
                  else if (!rx_empty) begin
                     o_rdata <= rx_mem[rx_rp_reg][7:0];
                     o_rx_upper_bits <= rx_mem[rx_rp_reg][10:8];
                  end
               end
               `STCR_OFS_CMD: o_rdata <= cmd_reg;
               `STCR_OFS_MODE: o_rdata <= mode_reg;
               `STCR_OFS_STATUS: o_rdata <= {3'h0, rx_cnt_reg[1:0], tx_cnt_reg};
               `STCR_OFS_ERRCODE: o_rdata <= {3'h0, ovf_reg | i_err_codes[4], i_err_codes[3:0]};
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Line-side outputs, all registered
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_tx_word <= 12'h000;
         o_tx_word_valid <= 1'b0;
         o_tx_serial <= 1'b0;
         o_tx_active_out <= 1'b0;
         o_rx_serial <= 1'b0;
         o_rx_enable <= 1'b0;
         o_xcvr_reset <= 1'b1;
         o_protocol_sel <= 3'h0;
         o_quiesce_3 <= 1'b0;
         o_rx_input_sel <= 1'b0;
         o_bidir_irq_pin_o <= 1'b0;
         o_bidir_irq_pin_oe <= 1'b0;
      end else begin
         o_tx_word <= tx_mem[tx_rp_reg];
         o_tx_word_valid <= !tx_empty && !xres;
         o_tx_serial <= i_tx_serial_raw ^ mode_reg[`STCR_M_TIN];
         // Early flavour of active gives the extra half quiesce bit
         o_tx_active_out <= !mode_reg[`STCR_M_LOOP] && !xres &&
            (cmd_reg[`STCR_C_ATA] ? i_tx_active_early : i_tx_active_raw);
         o_rx_serial <= rx_data;
         o_rx_enable <= !xres && (mode_reg[`STCR_M_REPEAT_ENABLE] || !i_tx_active_raw);
         o_xcvr_reset <= xres;
         o_protocol_sel <= proto;
         o_quiesce_3 <= cmd_reg[`STCR_C_RLQ];
         o_rx_input_sel <= cmd_reg[`STCR_C_SLR];
         o_bidir_irq_pin_o <= irq_ctl_reg[3];
         o_bidir_irq_pin_oe <= i_bidir_is_output;
      end
   end

endmodule // stcr_ctrl

// ---- hw/stcr_regs.vh ----
// Register offsets, field positions and reset values of the serial transceiver control bank
`ifndef STCR_REGS_VH
`define STCR_REGS_VH
`define STCR_ADDR_W 3
`define STCR_OFS_VBASE 3'h0
`define STCR_OFS_IRQCTL 3'h1
`define STCR_OFS_FLAGS 3'h2
`define STCR_OFS_FIFO 3'h3
`define STCR_OFS_CMD 3'h4
`define STCR_OFS_MODE 3'h5
`define STCR_OFS_STATUS 3'h6
`define STCR_OFS_ERRCODE 3'h7
`define STCR_RST_VBASE 8'h00
`define STCR_RST_IRQCTL 8'h00
`define STCR_RST_CMD 8'h00
`define STCR_RST_MODE 8'h00
// Flags register bit positions
`define STCR_F_TFE 7
`define STCR_F_RFF 6
`define STCR_F_LA 5
`define STCR_F_LTA 4
`define STCR_F_DATA_ERR_MSG_END 3
`define STCR_F_RAR 2
`define STCR_F_ACK 1
`define STCR_F_POLL 0
// Command register fields
`define STCR_C_RLQ 7
`define STCR_C_SEC 6
`define STCR_C_SLR 5
`define STCR_C_ATA 4
`define STCR_C_OWP 3
// Mode register fields
`define STCR_M_XCVR_RESET_BIT 7
`define STCR_M_LOOP 6
`define STCR_M_REPEAT_ENABLE 5
`define STCR_M_RIN 4
`define STCR_M_TIN 3
// Vector source codes
`define STCR_VEC_NMI 6'h1c
`define STCR_VEC_RX 6'h04
`define STCR_VEC_TX 6'h08
`define STCR_VEC_LTA 6'h0c
`define STCR_VEC_BIDIR 6'h10
`define STCR_VEC_TIMER 6'h14
// Receiver interrupt source select codes
`define STCR_RIS_FULL 2'h0
`define STCR_RIS_DAV 2'h1
`define STCR_RIS_ACTIVE 2'h3
// Protocol codes
`define STCR_PS_COAX 3'h0
`define STCR_PS_TWINAX 3'h4
`define STCR_PS_TWINAXP 3'h5
`define STCR_RX_FULL_WORDS 3
`define STCR_IDLE_XCLKS 16
`define STCR_FIFO_DEPTH 3
`endif

// ---- testbench/stcr_ctrl_monitor.sv ----
// Port checker for the serial transceiver control bank
`timescale 1ns/100ps
module stcr_ctrl_monitor (
   input wire i_clk,
   input wire i_reset_n,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_nmi,
   input wire i_rx_serial,
   input wire i_tx_serial_raw,
   input wire i_bidir_is_output,
   input wire [11:0] o_tx_word,
   input wire o_tx_word_valid,
   input wire o_tx_serial,
   input wire o_tx_active_out,
   input wire o_rx_serial,
   input wire o_xcvr_reset,
   input wire [2:0] o_protocol_sel,
   input wire o_quiesce_3,
   input wire o_irq,
   input wire [15:0] o_vector,
   input wire o_bidir_irq_pin_o,
   input wire o_bidir_irq_pin_oe
);
   reg [7:0] base_reg;
   reg [7:0] icr_reg;
   reg [7:0] cmd_reg;
   reg [7:0] mode_reg;
   reg [11:0] word_reg;
   // Shadow copies of the writable registers, taken at the same edge as the bank
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         base_reg <= 8'h00;
         icr_reg <= 8'h00;
         cmd_reg <= 8'h00;
         mode_reg <= 8'h00;
         word_reg <= 12'h000;
      end else if (i_wr) begin
         case (i_addr)
            3'h0: base_reg <= i_wdata;
            3'h1: icr_reg <= i_wdata;
            3'h3: word_reg <= {cmd_reg[3:0], i_wdata};
            3'h4: cmd_reg <= i_wdata;
            3'h5: mode_reg <= i_wdata;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   property p_vbase;
      o_irq && $past(i_reset_n) && $stable(base_reg) |-> o_vector[15:6] == {base_reg, 2'h0};
   endproperty
   a_vbase: assert property (p_vbase) else $error("vector high byte wrong");
   property p_nmi;
      i_nmi |=> o_irq && o_vector[5:0] == 6'h1c;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
   property p_bidir;
      i_bidir_is_output |=> o_bidir_irq_pin_oe && o_bidir_irq_pin_o == $past(icr_reg[3]);
   endproperty
   a_bidir: assert property (p_bidir) else $error("bidir pin level wrong");
   property p_push;
      i_wr && i_addr == 3'h3 && !cmd_reg[6] && !mode_reg[7] && !o_tx_word_valid
         |-> ##[1:2] o_tx_word_valid && o_tx_word == word_reg;
   endproperty
   a_push: assert property (p_push) else $error("tx entry wrong");
   property p_rlq;
      $past(i_reset_n) && $stable(cmd_reg) |-> o_quiesce_3 == cmd_reg[7];
   endproperty
   a_rlq: assert property (p_rlq) else $error("quiesce select wrong");
   property p_xcvr_reset_bit;
      $past(i_reset_n) && $stable(mode_reg) |-> o_xcvr_reset == mode_reg[7];
   endproperty
   a_xcvr_reset_bit: assert property (p_xcvr_reset_bit) else $error("transceiver reset wrong");
   property p_loop;
      mode_reg[6] && $past(i_reset_n) && $stable(mode_reg) |-> !o_tx_active_out;
   endproperty
   a_loop: assert property (p_loop) else $error("tx active in loopback");
   property p_tinv;
      $past(i_reset_n) && $stable(mode_reg) |-> o_tx_serial == ($past(i_tx_serial_raw) ^ mode_reg[3]);
   endproperty
   a_tinv: assert property (p_tinv) else $error("tx invert wrong");
   property p_rinv;
      $past(i_reset_n) && $stable(mode_reg) && !mode_reg[6]
         |-> o_rx_serial == ($past(i_rx_serial) ^ mode_reg[4]);
   endproperty
   a_rinv: assert property (p_rinv) else $error("rx invert wrong");
   property p_ps;
      $past(i_reset_n) && $stable(mode_reg) |-> o_protocol_sel == mode_reg[2:0];
   endproperty
   a_ps: assert property (p_ps) else $error("protocol select wrong");
endmodule // stcr_ctrl_monitor
bind stcr_ctrl stcr_ctrl_monitor mon_u (.*);

// ---- testbench/stcr_line_model.sv ----
// Transmitter-side model that takes words off the transmit FIFO
`timescale 1ns/100ps
module stcr_line_model (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_stall,
   input wire i_word_valid,
   input wire [11:0] i_word,
   output reg o_pop,
   output reg [2:0] o_count,
   output reg [47:0] o_words
);
   reg pop_d;
   // One take every third cycle: valid reflects a pop two edges later
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pop <= 1'b0;
         pop_d <= 1'b0;
         o_count <= 3'h0;
         o_words <= 48'h0;
      end else begin
         pop_d <= o_pop;
         o_pop <= i_word_valid && !o_pop && !pop_d && !i_stall;
         if (o_pop) begin
            o_words <= {o_words[35:0], i_word};
            o_count <= o_count + 3'h1;
         end
      end
   end
endmodule // stcr_line_model

// ---- testbench/stcr_ctrl_test.sv ----
// Self-checking bench for the serial transceiver control bank
`timescale 1ns/100ps
module stcr_ctrl_test;
   reg i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_xclk_en = 1'b0;
   reg [2:0] i_addr = 3'h0;
   reg [7:0] i_wdata = 8'h00;
   reg i_rx_serial = 1'b0, i_tx_serial_raw = 1'b0, i_tx_active_raw = 1'b0;
   reg i_tx_active_early = 1'b0, i_rx_push = 1'b0, i_rx_msg_end = 1'b0, i_rx_active = 1'b0;
   reg [10:0] i_rx_word = 11'h000;
   reg i_rx_error = 1'b0, i_rx_parity_err = 1'b0, i_rx_addr7 = 1'b0, i_rx_autoresp = 1'b0;
   reg i_rx_pollack = 1'b0, i_rx_poll = 1'b0, i_bidir_is_output = 1'b0, i_tx_irq_cause = 1'b0;
   reg [4:0] i_err_codes = 5'h00;
   reg i_bidir_irq_in = 1'b0, i_timer_irq_cause = 1'b0, i_nmi = 1'b0, stall = 1'b1;
   wire i_tx_pop, o_tx_word_valid, o_tx_serial, o_tx_active_out, o_rx_serial, o_rx_enable;
   wire o_xcvr_reset, o_quiesce_3, o_rx_input_sel, o_err_read, o_irq;
   wire o_bidir_irq_pin_o, o_bidir_irq_pin_oe;
   wire [7:0] o_rdata;
   wire [11:0] o_tx_word;
   wire [2:0] o_protocol_sel, o_rx_upper_bits, taken;
   wire [15:0] o_vector;
   wire [47:0] words;
   reg [31:0] seed = 32'h6cd07c62;
   reg [15:0] cyc = 16'h0;
   reg [47:0] exp_w = 48'h0;
   reg [10:0] rw [0:2];
   reg [7:0] d, base;
   reg [3:0] eq;
   integer i, n_mismatch = 0, n_tests = 0;
   stcr_ctrl dut_u (.*);
   stcr_line_model line_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_stall(stall),
      .i_word_valid(o_tx_word_valid), .i_word(o_tx_word), .o_pop(i_tx_pop),
      .o_count(taken), .o_words(words));
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Receiver cause for each source select code, FIFO kept empty
   function f_rx(input [1:0] r, input e, input a);
      f_rx = ((r == 2'h0 || r == 2'h1) && e) || (r == 2'h3 && a);
   endfunction
   function [5:0] f_vec(input [2:0] k);
      f_vec = {1'b0, k + 3'h1, 2'h0};
   endfunction
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [8*12-1:0] nm, input [47:0] got, input [47:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] v);
      begin
         @(posedge i_clk);
         i_addr <= a;
         i_wdata <= v;
         i_wr <= 1'b1;
         @(posedge i_clk);
         i_wr <= 1'b0;
      end
   endtask
   // Read answer is taken at the edge after the strobe, the only cycle it stands
   task rc(input [2:0] a, input [7:0] e, input [7:0] m, input [8*12-1:0] nm);
      begin
         @(posedge i_clk);
         i_addr <= a;
         i_rd <= 1'b1;
         @(posedge i_clk);
         i_rd <= 1'b0;
         @(posedge i_clk);
         d = o_rdata;
         chk(nm, d & m, e & m);
      end
   endtask
   task pulse_end;
      begin
         i_rx_msg_end <= 1'b1;
         @(posedge i_clk);
         i_rx_msg_end <= 1'b0;
      end
   endtask
   // Transceiver clock enable every fourth cycle, tx data pattern, run limit
   always @(posedge i_clk) begin
      cyc <= cyc + 16'h1;
      i_xclk_en <= (cyc[1:0] == 2'h3);
      i_tx_serial_raw <= cyc[0] ^ cyc[3];
      if (cyc == 16'd6000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1) if (i != 3) rc(i, i == 2 ? 8'h80 : 8'h00, 8'hdf, "reset");
      for (i = 0; i < 12; i = i + 1) begin
         seed = xs(seed);
         wr(i % 6 == 3 ? 3'h4 : i % 6 % 6, seed[7:0]);
         if (i % 6 != 2) rc(i % 6 == 3 ? 3'h4 : i % 6, seed[7:0], 8'hdf, "readback");
      end
      wr(3'h4, 8'h00);
      wr(3'h5, 8'h00);
      $display("registers done");
      for (i = 0; i < 8; i = i + 1) begin
         i_rx_error <= i[2];
         i_rx_active <= !i[2];
         wr(3'h1, {i[1:0], 6'h1e});
         repeat (2) @(posedge i_clk);
         chk("rx cause", o_irq, f_rx(i[1:0], i[2], !i[2]));
      end
      seed = xs(seed);
      base = seed[7:0];
      wr(3'h0, base);
      i_tx_irq_cause <= 1'b1;
      i_bidir_irq_in <= 1'b1;
      i_timer_irq_cause <= 1'b1;
      pulse_end;
      for (i = 0; i < 5; i = i + 1) begin
         wr(3'h1, (8'h01 << i) - 8'h01);
         repeat (2) @(posedge i_clk);
         chk("vector", o_vector, {base, 2'h0, f_vec(i)});
      end
      wr(3'h1, 8'h1f);
      repeat (2) @(posedge i_clk);
      chk("all masked", o_irq, 1'b0);
      i_nmi <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk("nmi", o_vector, {base, 8'h1c});
      i_nmi <= 1'b0;
      i_bidir_is_output <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         wr(3'h1, 8'h17 | (i << 3));
         repeat (2) @(posedge i_clk);
         chk("bidir pin", {o_bidir_irq_pin_oe, o_bidir_irq_pin_o}, {1'b1, i[0]});
         chk("bidir irq", o_irq, 1'b0);
      end
      {i_bidir_is_output, i_rx_error, i_tx_irq_cause, i_bidir_irq_in, i_timer_irq_cause} <= 5'h0;
      $display("interrupts done");
      // Stalled far side: fill the transmit FIFO, one push too many
      for (i = 0; i < 4; i = i + 1) begin
         seed = xs(seed);
         wr(3'h4, {4'h0, seed[11:8]});
         wr(3'h3, seed[7:0]);
         if (i < 3) exp_w = {exp_w[35:0], seed[11:0]};
      end
      rc(3'h2, 8'h00, 8'h80, "tx empty");
      stall <= 1'b0;
      repeat (20) @(posedge i_clk);
      chk("tx words", words, exp_w);
      chk("tx count", taken, 3'h3);
      rc(3'h2, 8'h80, 8'h80, "tx empty");
      $display("transmit done");
      for (i = 0; i < 3; i = i + 1) begin
         pulse_end;
         wr(3'h2, 8'h00);
         rc(3'h2, 8'h10, 8'h10, "turnaround");
         wr(i == 0 ? 3'h2 : (i == 1 ? 3'h3 : 3'h5), i == 2 ? 8'h80 : 8'h10);
         rc(3'h2, 8'h00, 8'h10, "turnaround");
         wr(3'h5, 8'h00);
      end
      $display("turnaround done");
      eq = 4'h0;
      for (i = 0; i < 3; i = i + 1) begin
         seed = xs(seed);
         rw[i] = seed[10:0];
         eq = eq | seed[14:11];
         i_rx_push <= 1'b1;
         i_rx_word <= seed[10:0];
         {i_rx_parity_err, i_rx_autoresp, i_rx_pollack, i_rx_poll} <= seed[14:11];
         @(posedge i_clk);
         i_rx_push <= 1'b0;
         rc(3'h2, i == 2 ? 8'h40 : 8'h00, 8'h40, "rx full");
      end
      rc(3'h2, {4'h0, eq}, 8'h0f, "rx flags");
      for (i = 0; i < 3; i = i + 1) begin
         rc(3'h3, rw[i][7:0], 8'hff, "rx byte");
         chk("rx upper", o_rx_upper_bits, rw[i][10:8]);
      end
      rc(3'h2, 8'h00, 8'h4f, "rx flags");
      // Twinax mode: address seven marks the message end
      wr(3'h5, 8'h04);
      i_rx_push <= 1'b1;
      i_rx_addr7 <= 1'b1;
      @(posedge i_clk);
      i_rx_push <= 1'b0;
      i_rx_addr7 <= 1'b0;
      rc(3'h2, 8'h08, 8'h0f, "twinax end");
      rc(3'h3, rw[2][7:0], 8'hff, "rx byte");
      rc(3'h2, 8'h00, 8'h0f, "twinax end");
      wr(3'h5, 8'h00);
      seed = xs(seed);
      i_err_codes <= seed[4:0];
      wr(3'h4, 8'h40);
      rc(3'h3, {3'h0, seed[4:0]}, 8'h1f, "error codes");
      chk("err read", o_err_read, 1'b1);
      wr(3'h4, 8'h00);
      $display("receive done");
      i_rx_serial <= 1'b1;
      repeat (40) @(posedge i_clk);
      rc(3'h2, 8'h20, 8'h20, "line active");
      repeat (40) @(posedge i_clk);
      rc(3'h2, 8'h00, 8'h20, "line idle");
      $display("line active done");
      for (i = 0; i < 8; i = i + 1) begin
         seed = xs(seed);
         wr(3'h4, {seed[9], 2'h0, seed[10], 4'h0});
         wr(3'h5, {1'b0, seed[6:3], i[2:0]});
         i_tx_active_raw <= seed[8];
         i_tx_active_early <= seed[7];
         i_rx_active <= 1'b1;
         repeat (3) @(posedge i_clk);
         chk("protocol", o_protocol_sel, i[2:0]);
         if (!seed[6]) chk("rx enable", o_rx_enable, seed[5] | !seed[8]);
         d = {7'h0, seed[10] ? seed[7] : seed[8]};
         chk("tx active", o_tx_active_out, !seed[6] & d[0]);
      end
      $display("mode done");
      give_verdict;
   end
endmodule // stcr_ctrl_test
